// ==== inc/bmad_defs.vh ====
// Address map and port constants for the bus matrix decoder
`ifndef BMAD_DEFS_VH
`define BMAD_DEFS_VH
`define BMAD_N_INIT 6
`define BMAD_N_TGT 16
`define BMAD_AW 32
`define BMAD_DW 32
// Initiator ports
`define BMAD_S_DMA_A 3'h0
`define BMAD_S_DMA_B 3'h1
`define BMAD_S_DMA_C 3'h2
`define BMAD_S_SBUS 3'h3
`define BMAD_S_DBUS 3'h4
`define BMAD_S_IBUS 3'h5
// Target ports
`define BMAD_M_FLASH_I 4'h0
`define BMAD_M_FLASH_D 4'h1
`define BMAD_M_FLASH_MIR 4'h2
`define BMAD_M_RAM0 4'h3
`define BMAD_M_RAM1 4'h4
`define BMAD_M_RAM2 4'h5
`define BMAD_M_RAM3 4'h6
`define BMAD_M_RAM4 4'h7
`define BMAD_M_BKRAM 4'h8
`define BMAD_M_BOOTROM 4'h9
`define BMAD_M_EXTBUS 4'hA
`define BMAD_M_PERI 4'hB
`define BMAD_M_EBI_REG 4'hC
`define BMAD_M_NAND_ECC 4'hD
`define BMAD_M_NAND_SEQ 4'hE
`define BMAD_M_PERI_LOW 4'hF
// Region boundaries
`define BMAD_A_FLASH_END 32'h0010_0000
`define BMAD_A_BOOT_END 32'h0000_1000
`define BMAD_A_MIR_BASE 32'h1000_0000
`define BMAD_A_MIR_END 32'h1004_0000
`define BMAD_A_RAM0 32'h2000_0000
`define BMAD_A_RAM1 32'h2004_0000
`define BMAD_A_RAM2 32'h2004_4000
`define BMAD_A_RAM3 32'h2004_8000
`define BMAD_A_RAM4 32'h2004_C000
`define BMAD_A_BKRAM 32'h2008_0000
`define BMAD_A_BKRAM_END 32'h2008_0800
`define BMAD_A_SBB_BASE 32'h2200_0000
`define BMAD_A_SBB_END 32'h2301_0000
`define BMAD_A_RSV_BASE 32'h3F7F_F000
`define BMAD_A_RSV_END 32'h3F80_0000
`define BMAD_A_PERI_BASE 32'h4000_0000
`define BMAD_A_PERI_OK 32'h4004_0000
`define BMAD_A_EBI_REG 32'h4005_C000
`define BMAD_A_NAND_ECC 32'h4005_C800
`define BMAD_A_NAND_SEQ 32'h4005_CC00
`define BMAD_A_DMARQ 32'h4005_F000
`define BMAD_A_PORTS 32'h400C_0000
`define BMAD_A_PERI_END 32'h4010_0000
`define BMAD_A_PBB_BASE 32'h4280_0000
`define BMAD_A_PBB_END 32'h4400_0000
`define BMAD_A_FCTL 32'h5DFF_0000
`define BMAD_A_FMIR 32'h5E00_0000
`define BMAD_A_FMIR_END 32'h5E10_0000
`define BMAD_A_EXT_BASE 32'h6000_0000
`define BMAD_A_EXT_END 32'h6400_0000
`endif

// ==== verilog/bmad_matrix.v ====
// Bus matrix with per-initiator address decode and fixed-priority arbitration
`timescale 1ns/1ps
`include "bmad_defs.vh"
// Operation
// - Fault-region access never reaches a target and returns an error answer.
// - Six initiator ports S0..S5 and sixteen target ports M0..M15.
// - Same-cycle requests to one target: lowest initiator number wins.
// - Chip mode low 1 MB flash: I-bus to M0, D-bus to M1, others fault.
// - RAM0 mirror at 0x1000_0000 via M3 for D/I buses only.
// - Main RAM banks and backup RAM on M3..M8 for DMA and system bus.
// - SRAM bit-band alias reachable from system bus only.
// - Boot mode: boot ROM on M9 for D/I buses, rest to 0x1000_0000 faults.
// - Low peripheral range faults for all; peripherals fault from D/I buses.
// - External bus registers on M12: DMA A and system bus only.
// - NAND ECC on M13 for DMA B, NAND sequencer on M14 for DMA C.
// - DMA request interface through arithmetic block: DMA C and system bus.
// - Peripheral bit-band alias reachable from system bus only.
// - Flash control on M15 for DMA and system; mirror on M2 for A and system.
// - External bus window on M10 for DMA and system bus; beyond faults.
module bmad_matrix #(
	parameter NI = `BMAD_N_INIT,
	parameter NT = `BMAD_N_TGT,
	parameter AW = `BMAD_AW,
	parameter DW = `BMAD_DW
)(
	// Clock and reset
	input wire CLK,
	input wire RESET,
	// Mode strap
	input wire BOOT_MODE,
	// Initiator side
	input wire [NI-1:0] I_REQ,
	input wire [NI*AW-1:0] I_ADDR,
	input wire [NI-1:0] I_WRITE,
	input wire [NI*DW-1:0] I_WDATA,
	output reg [NI-1:0] I_ACK,
	output reg [NI-1:0] I_ERR,
	output reg [NI*DW-1:0] I_RDATA,
	// Target side
	output reg [NT-1:0] T_VALID,
	output reg [NT*AW-1:0] T_ADDR,
	output reg [NT-1:0] T_WRITE,
	output reg [NT*DW-1:0] T_WDATA,
	output reg [NT*3-1:0] T_SRC,
	input wire [NT-1:0] T_READY,
	input wire [NT*DW-1:0] T_RDATA,
	// Mode status
	output reg BOOT_SEL
);

// ----------------------------------------
// Decode
// ----------------------------------------
function [4:0] route;
	input [31:0] a;
	input [2:0] s;
	input boot;
	reg dma, sb, core;
	begin
		dma = (s == `BMAD_S_DMA_A) || (s == `BMAD_S_DMA_B) ||
			(s == `BMAD_S_DMA_C);
		sb = (s == `BMAD_S_SBUS);
		core = (s == `BMAD_S_DBUS) || (s == `BMAD_S_IBUS);
		route = {1'b1, 4'h0};
		if (a < `BMAD_A_MIR_BASE)
		begin
			if (boot)
			begin
				if (a < `BMAD_A_BOOT_END && core)
					route = {1'b0, `BMAD_M_BOOTROM};
			end
			else if (a < `BMAD_A_FLASH_END)
			begin
				if (s == `BMAD_S_IBUS)
					route = {1'b0, `BMAD_M_FLASH_I};
				else if (s == `BMAD_S_DBUS)
					route = {1'b0, `BMAD_M_FLASH_D};
			end
		end
		else if (a < `BMAD_A_MIR_END)
		begin
			if (core)
				route = {1'b0, `BMAD_M_RAM0};
		end
		else if (a >= `BMAD_A_RAM0 && a < `BMAD_A_BKRAM_END)
		begin
			if (dma || sb)
			begin
				if (a < `BMAD_A_RAM1)
					route = {1'b0, `BMAD_M_RAM0};
				else if (a < `BMAD_A_RAM2)
					route = {1'b0, `BMAD_M_RAM1};
				else if (a < `BMAD_A_RAM3)
					route = {1'b0, `BMAD_M_RAM2};
				else if (a < `BMAD_A_RAM4)
					route = {1'b0, `BMAD_M_RAM3};
				else if (a < `BMAD_A_BKRAM)
					route = {1'b0, `BMAD_M_RAM4};
				else
					route = {1'b0, `BMAD_M_BKRAM};
			end
		end
		else if (a >= `BMAD_A_SBB_BASE && a < `BMAD_A_SBB_END)
		begin
			if (sb)
				route = {1'b0, `BMAD_M_RAM0};
		end
		else if (a >= `BMAD_A_PERI_OK && a < `BMAD_A_PERI_END)
		begin
			if (a < `BMAD_A_EBI_REG)
			begin
				if (dma || sb)
					route = {1'b0, `BMAD_M_PERI};
			end
			else if (a < `BMAD_A_NAND_ECC)
			begin
				if (s == `BMAD_S_DMA_A || sb)
					route = {1'b0, `BMAD_M_EBI_REG};
			end
			else if (a < `BMAD_A_NAND_SEQ)
			begin
				if (s == `BMAD_S_DMA_B || sb)
					route = {1'b0, `BMAD_M_NAND_ECC};
			end
			else if (a < `BMAD_A_PORTS)
			begin
				if (s == `BMAD_S_DMA_C || sb)
					route = {1'b0, `BMAD_M_NAND_SEQ};
			end
			else if (dma || sb)
				route = {1'b0, `BMAD_M_PERI_LOW};
		end
		else if (a >= `BMAD_A_PBB_BASE && a < `BMAD_A_PBB_END)
		begin
			if (sb)
				route = {1'b0, `BMAD_M_PERI};
		end
		else if (a >= `BMAD_A_FCTL && a < `BMAD_A_FMIR)
		begin
			if (dma || sb)
				route = {1'b0, `BMAD_M_PERI_LOW};
		end
		else if (a >= `BMAD_A_FMIR && a < `BMAD_A_FMIR_END)
		begin
			if (s == `BMAD_S_DMA_A || sb)
				route = {1'b0, `BMAD_M_FLASH_MIR};
		end
		else if (a >= `BMAD_A_EXT_BASE && a < `BMAD_A_EXT_END)
		begin
			if (dma || sb)
				route = {1'b0, `BMAD_M_EXTBUS};
		end
	end
endfunction

// ----------------------------------------
// Boot mode capture
// ----------------------------------------
reg [2:0] boot_sync;
reg [2:0] boot_fill;
reg boot_done;

always @(posedge CLK or posedge RESET)
begin
	if (RESET)
	begin
		boot_sync <= 3'h0;
		boot_fill <= 3'h0;
		boot_done <= 1'b0;
		BOOT_SEL <= 1'b0;
	end
	else
	begin
		boot_sync <= {boot_sync[1:0], BOOT_MODE};
		// Wait until the third stage holds a real pin sample
		boot_fill <= {boot_fill[1:0], 1'b1};
		if (!boot_done && boot_fill[2] && (boot_sync[1] == boot_sync[2]))
		begin
			boot_done <= 1'b1;
			BOOT_SEL <= boot_sync[2];
		end
	end
end

// ----------------------------------------
// Arbitration
// ----------------------------------------
reg [NI-1:0] pend;
reg [NT-1:0] busy;
reg [NT*3-1:0] owner;
reg [NI-1:0] fault;
reg [NI*4-1:0] tgt;
reg [NI-1:0] ready_i;
reg [NT*3-1:0] win;
reg [NT-1:0] any;
reg [NI-1:0] granted;
reg [NI-1:0] done;
reg [NI*DW-1:0] done_data;
reg [4:0] r;
integer i;
integer t;
integer k;
integer j;

always @*
begin
	r = 5'h00;
	fault = {NI{1'b0}};
	tgt = {(NI*4){1'b0}};
	win = {(NT*3){1'b0}};
	any = {NT{1'b0}};
	granted = {NI{1'b0}};
	done = {NI{1'b0}};
	done_data = {(NI*DW){1'b0}};
	// Only a new request, not pending and not being answered, competes
	ready_i = I_REQ & ~pend & ~I_ACK & {NI{boot_done}};
	for (i = 0; i < NI; i = i + 1)
	begin
		r = route(I_ADDR[i*AW +: AW], i[2:0], BOOT_SEL);
		fault[i] = r[4];
		tgt[i*4 +: 4] = r[3:0];
	end
	for (t = 0; t < NT; t = t + 1)
	begin
		for (i = NI - 1; i >= 0; i = i - 1)
		begin
			if (ready_i[i] && !fault[i] && tgt[i*4 +: 4] == t[3:0])
			begin
				win[t*3 +: 3] = i[2:0];
				any[t] = 1'b1;
			end
		end
		if (!busy[t] && any[t])
			granted[win[t*3 +: 3]] = 1'b1;
		if (busy[t] && T_READY[t])
		begin
			done[owner[t*3 +: 3]] = 1'b1;
			done_data[owner[t*3 +: 3]*DW +: DW] = T_RDATA[t*DW +: DW];
		end
	end
end

// ----------------------------------------
// Target ports
// ----------------------------------------
always @(posedge CLK or posedge RESET)
begin
	if (RESET)
	begin
		busy <= {NT{1'b0}};
		owner <= {(NT*3){1'b0}};
		T_VALID <= {NT{1'b0}};
		T_ADDR <= {(NT*AW){1'b0}};
		T_WRITE <= {NT{1'b0}};
		T_WDATA <= {(NT*DW){1'b0}};
		T_SRC <= {(NT*3){1'b0}};
	end
	else
	begin
		for (k = 0; k < NT; k = k + 1)
		begin
			if (busy[k])
			begin
				if (T_READY[k])
				begin
					busy[k] <= 1'b0;
					T_VALID[k] <= 1'b0;
				end
			end
			else if (any[k])
			begin
				busy[k] <= 1'b1;
				owner[k*3 +: 3] <= win[k*3 +: 3];
				T_VALID[k] <= 1'b1;
				T_SRC[k*3 +: 3] <= win[k*3 +: 3];
				T_ADDR[k*AW +: AW] <= I_ADDR[win[k*3 +: 3]*AW +: AW];
				T_WRITE[k] <= I_WRITE[win[k*3 +: 3]];
				T_WDATA[k*DW +: DW] <= I_WDATA[win[k*3 +: 3]*DW +: DW];
			end
		end
	end
end

// ----------------------------------------
// Initiator answers
// ----------------------------------------
always @(posedge CLK or posedge RESET)
begin
	if (RESET)
	begin
		pend <= {NI{1'b0}};
		I_ACK <= {NI{1'b0}};
		I_ERR <= {NI{1'b0}};
		I_RDATA <= {(NI*DW){1'b0}};
	end
	else
	begin
		for (j = 0; j < NI; j = j + 1)
		begin
			I_ACK[j] <= 1'b0;
			I_ERR[j] <= 1'b0;
			if (ready_i[j] && fault[j])
			begin
				I_ACK[j] <= 1'b1;
				I_ERR[j] <= 1'b1;
				I_RDATA[j*DW +: DW] <= {DW{1'b0}};
			end
			else if (granted[j])
				pend[j] <= 1'b1;
			else if (done[j])
			begin
				pend[j] <= 1'b0;
				I_ACK[j] <= 1'b1;
				I_RDATA[j*DW +: DW] <= done_data[j*DW +: DW];
			end
		end
	end
end

endmodule

// ==== dv/bmad_props_properties.sv ====
// Concurrent checks on the bus matrix ports
`timescale 1ns/1ps
module bmad_props (
	// Clock and reset
	input wire CLK,
	input wire RESET,
	// Initiator side
	input wire [5:0] I_REQ,
	input wire [5:0] I_ACK,
	input wire [5:0] I_ERR,
	input wire [191:0] I_RDATA,
	// Target side
	input wire [15:0] T_VALID,
	input wire [47:0] T_SRC,
	input wire [15:0] T_READY,
	input wire [511:0] T_RDATA,
	// Mode status
	input wire BOOT_SEL
);
	// ----
	// Port relations
	// ----
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (RESET);
	a_err_with_ack: assert property ((I_ERR & ~I_ACK) == 6'h00)
		else $error("error answer without ack");
	a_err_no_data: assert property (I_ERR[3] |-> I_RDATA[127:96] == 32'h0)
		else $error("error answer carries data");
	a_ack_held_req: assert property ((I_ACK & ~$past(I_REQ)) == 6'h00)
		else $error("ack without held request");
	a_valid_hold: assert property (($past(T_VALID & ~T_READY) & ~T_VALID) == 16'h0)
		else $error("target request dropped early");
	a_grant_gap: assert property (($past(T_VALID & T_READY) & T_VALID) == 16'h0)
		else $error("regrant without idle cycle");
	a_flash_src: assert property (T_VALID[0] |-> T_SRC[2:0] == 3'h5 && !BOOT_SEL)
		else $error("flash code port bad source");
	a_ram_src: assert property (T_VALID[4] |-> T_SRC[14:12] < 3'h4)
		else $error("ram bank from core code bus");
	a_boot_rom: assert property (T_VALID[9] |-> BOOT_SEL && T_SRC[29:27] > 3'h3)
		else $error("boot rom bad source or mode");
	a_ebi_src: assert property (T_VALID[12] |-> T_SRC[38:36] inside {3'h0, 3'h3})
		else $error("bus interface regs bad source");
	a_seq_src: assert property (T_VALID[14] |-> T_SRC[44:42] inside {3'h2, 3'h3})
		else $error("nand sequencer bad source");
	a_ram_answer: assert property (T_VALID[3] && T_READY[3] && T_SRC[11:9] == 3'h0
		|=> I_ACK[0] && !I_ERR[0] && I_RDATA[31:0] == $past(T_RDATA[127:96]))
		else $error("ram answer not returned");
endmodule
bind bmad_matrix bmad_props u_props (.CLK(CLK), .RESET(RESET), .I_REQ(I_REQ),
	.I_ACK(I_ACK), .I_ERR(I_ERR), .I_RDATA(I_RDATA), .T_VALID(T_VALID),
	.T_SRC(T_SRC), .T_READY(T_READY), .T_RDATA(T_RDATA), .BOOT_SEL(BOOT_SEL));

// ==== dv/bmad_tgt_model.sv ====
// Target side model answering every matrix port
`timescale 1ns/1ps
module bmad_tgt (
	// Clock and reset
	input wire CLK,
	input wire RESET,
	// Matrix side
	input wire [15:0] valid,
	input wire [511:0] addr,
	input wire slow,
	output reg [15:0] ready,
	output reg [511:0] rdata
);
	// ----
	// Answer logic
	// ----
	reg tick;
	integer k;
	always @(posedge CLK or posedge RESET)
	begin
		if (RESET)
		begin
			ready <= 16'h0000;
			rdata <= 512'h0;
			tick <= 1'b0;
		end
		else
		begin
			tick <= ~tick;
			for (k = 0; k < 16; k = k + 1)
			begin
				ready[k] <= valid[k] & ~ready[k] & (~slow | tick);
				rdata[k*32+:32] <= (valid[k] & ~ready[k]) ?
					addr[k*32+:32] ^ 32'hA5A5_A5A5 : ~rdata[k*32+:32];
			end
		end
	end
endmodule

// ==== dv/bmad_matrix_bench.sv ====
// Self-checking bench for the bus matrix decoder
`timescale 1ns/1ps
module bmad_matrix_bench;
	// ----
	// Wiring
	// ----
	reg CLK = 0, RESET = 1, BOOT_MODE = 0, slow = 0;
	reg [5:0] I_REQ = 0, I_WRITE = 0;
	reg [191:0] I_ADDR = 0, I_WDATA = 0;
	wire [5:0] I_ACK, I_ERR;
	wire [191:0] I_RDATA;
	wire [15:0] T_VALID, T_WRITE, T_READY;
	wire [511:0] T_ADDR, T_WDATA, T_RDATA;
	wire [47:0] T_SRC;
	wire BOOT_SEL;
	integer err_total = 0;
	integer n_checks = 0;
	bmad_matrix uut (.CLK(CLK), .RESET(RESET), .BOOT_MODE(BOOT_MODE),
		.I_REQ(I_REQ), .I_ADDR(I_ADDR), .I_WRITE(I_WRITE), .I_WDATA(I_WDATA),
		.I_ACK(I_ACK), .I_ERR(I_ERR), .I_RDATA(I_RDATA), .T_VALID(T_VALID),
		.T_ADDR(T_ADDR), .T_WRITE(T_WRITE), .T_WDATA(T_WDATA), .T_SRC(T_SRC),
		.T_READY(T_READY), .T_RDATA(T_RDATA), .BOOT_SEL(BOOT_SEL));
	bmad_tgt model (.CLK(CLK), .RESET(RESET), .valid(T_VALID), .addr(T_ADDR),
		.slow(slow), .ready(T_READY), .rdata(T_RDATA));
	always #4 CLK = ~CLK;
	// ----
	// Tasks
	// ----
	task end_sim;
	begin
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	end
	endtask
	task chk(input [31:0] g, input [31:0] e);
	begin
		n_checks = n_checks + 1;
		if (g !== e)
		begin
			err_total = err_total + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	end
	endtask
	task rst(input m);
	begin
		BOOT_MODE = m;
		RESET = 1;
		repeat (20) @(negedge CLK);
		RESET = 0;
		repeat (5) @(negedge CLK);
	end
	endtask
	task acc(input [2:0] i, input [31:0] a, input [4:0] t, input w);
		integer n, k;
		reg [4:0] got;
		reg ok;
		reg wr;
		reg [31:0] ad, wd;
	begin
		got = 16;
		ok = 0;
		wr = 0;
		ad = 0;
		wd = 0;
		I_ADDR[i*32+:32] = a;
		I_WDATA[i*32+:32] = ~a;
		I_WRITE[i] = w;
		I_REQ[i] = 1;
		for (n = 0; n < 20 && !ok; n = n + 1)
		begin
			@(negedge CLK);
			for (k = 0; k < 16; k = k + 1)
				if (T_VALID[k] === 1'b1 && T_SRC[k*3+:3] === i)
				begin
					got = k;
					wr = T_WRITE[k];
					ad = T_ADDR[k*32+:32];
					wd = T_WDATA[k*32+:32];
				end
			ok = I_ACK[i] === 1'b1;
		end
		I_REQ[i] = 0;
		chk(ok, 1);
		chk(got, t);
		chk(I_ERR[i], t == 16);
		if (t != 16)
		begin
			chk(ad, a);
			chk(wr, w);
			chk(wd, ~a);
		end
		if (!w)
			chk(I_RDATA[i*32+:32], t == 16 ? 0 : a ^ 32'hA5A5_A5A5);
		@(negedge CLK);
	end
	endtask
	task t_chip;
	begin
		acc(5, 32'h0000_0000, 0, 0);
		acc(4, 32'h000F_FFFC, 1, 1);
		acc(4, 32'h0010_0000, 16, 0);
		acc(0, 32'h0000_0000, 16, 0);
		acc(3, 32'h0000_0100, 16, 0);
		acc(4, 32'h1000_0000, 3, 0);
		acc(3, 32'h1003_FFFC, 16, 0);
		acc(2, 32'h2004_C000, 7, 0);
		acc(1, 32'h2008_0000, 8, 1);
		acc(4, 32'h2000_0000, 16, 0);
		acc(3, 32'h2200_0000, 3, 0);
		acc(0, 32'h2200_0000, 16, 0);
		acc(3, 32'h4000_0000, 16, 0);
		acc(4, 32'h4004_8000, 16, 0);
		acc(1, 32'h4004_9000, 11, 0);
		acc(0, 32'h4005_C000, 12, 0);
		acc(1, 32'h4005_C400, 16, 0);
		acc(1, 32'h4005_C800, 13, 0);
		acc(2, 32'h4005_CC00, 14, 0);
		acc(2, 32'h4005_F000, 14, 0);
		acc(0, 32'h400B_9000, 16, 0);
		acc(3, 32'h4280_0000, 11, 0);
		acc(2, 32'h4280_0000, 16, 0);
		acc(1, 32'h5DFF_0000, 15, 0);
		acc(0, 32'h5E00_0000, 2, 0);
		acc(1, 32'h5E00_0000, 16, 0);
		acc(2, 32'h6000_0000, 10, 0);
		acc(3, 32'h6400_0000, 16, 0);
		$display("test chip_map done");
	end
	endtask
	task t_arb;
		integer n;
		reg [2:0] done;
	begin
		done = 0;
		I_ADDR[95:0] = {32'h6000_0000, 32'h2000_0010, 32'h2000_0000};
		I_REQ[2:0] = 3'h7;
		@(negedge CLK);
		chk(T_SRC[11:9], 0);
		chk(T_VALID[10], 1);
		for (n = 0; n < 30 && done != 3'h7; n = n + 1)
		begin
			@(negedge CLK);
			if (I_ACK[1] === 1'b1)
				chk(done[0], 1);
			done = done | I_ACK[2:0];
			I_REQ[2:0] = I_REQ[2:0] & ~I_ACK[2:0];
		end
		chk(done, 7);
		@(negedge CLK);
		$display("test arbitration done");
	end
	endtask
	task t_boot;
	begin
		chk(BOOT_SEL, 1);
		acc(5, 32'h0000_0000, 9, 0);
		acc(4, 32'h0000_0FFC, 9, 0);
		acc(4, 32'h0000_1000, 16, 0);
		acc(3, 32'h0000_0000, 16, 0);
		acc(4, 32'h3F7F_F000, 16, 0);
		acc(5, 32'h1000_0000, 3, 0);
		BOOT_MODE = 0;
		repeat (5) @(negedge CLK);
		chk(BOOT_SEL, 1);
		acc(5, 32'h0000_0000, 9, 0);
		$display("test boot_map done");
	end
	endtask
	// ----
	// Sequence
	// ----
	initial
	begin
		#100000;
		err_total = err_total + 1;
		end_sim;
	end
	initial
	begin
		rst(0);
		chk(BOOT_SEL, 0);
		t_chip;
		t_arb;
		slow = 1;
		t_arb;
		acc(1, 32'h2004_0000, 4, 0);
		rst(1);
		t_boot;
		end_sim;
	end
endmodule
